/* logic/core_exec_pkg.sv */
// package: instruction encodings, carriers and register map of the add/bit execution unit
package core_exec_pkg;

    // instruction kinds understood by the unit
    typedef enum logic [2:0] {
        NO_OPERATION,
        ADD_IMMEDIATE_TO_ACC,
        ADD_ACC_AND_FILE,
        MASK_IMMEDIATE_WITH_ACC,
        MASK_ACC_WITH_FILE,
        FILE_BIT_CLEAR_OP,
        FILE_BIT_SET_OP,
        TEST_BIT_SKIP_ON_ZERO
    } op_type;

    // one decoded instruction as handed over by the decoder
    typedef struct packed {
        op_type op;
        logic [6:0] fileAddr;
        logic [2:0] bitSel;
        logic dest;
        logic [7:0] literal;
    } instr_type;

    // write-back request towards the data register file
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } file_wr_type;

    // destination operand encoding
    localparam logic DEST_ACC = 1'b0;

    // status flag positions inside the flag vector
    localparam int FLAG_C = 0;
    localparam int FLAG_NIB = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_W = 3;

    // carry positions of the adder
    localparam int CARRY_BIT = 8;
    localparam int NIBBLE_CARRY_BIT = 4;

    // apb register byte addresses
    localparam int APB_ADDR_W = 8;
    localparam logic [APB_ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [APB_ADDR_W-1:0] ADDR_ACC = 8'h04;
    localparam logic [APB_ADDR_W-1:0] ADDR_FLAGS = 8'h08;

    // reset values
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 3'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : core_exec_pkg

/* logic/core_add_and_bit_exec_unit.sv */
// add, mask and bit-manipulation execution unit with apb access to its state
//
// Summary of operation
// - immediate add into accumulator, updates all flags
// - accumulator plus file register, updates all flags
// - destination bit picks accumulator or file register
// - bit clear in file register, flags untouched
// - bit set in file register, flags untouched
// - immediate mask into accumulator, only Z changes
// - accumulator masked with file, routed, only Z
// - tested bit one: next instruction runs, flags kept
// - tested bit zero: next instruction becomes no-op
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps

module core_add_and_bit_exec_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic instrValid,
    input wire core_exec_pkg::instr_type instr,
    input wire logic [7:0] fileRdData,
    output core_exec_pkg::file_wr_type fileWr,
    output logic skipNext,
    output logic [7:0] acc,
    output logic [core_exec_pkg::FLAG_W-1:0] flags,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [core_exec_pkg::APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] acc_reg; // accumulator
    logic [core_exec_pkg::FLAG_W-1:0] flags_reg; // carry, nibble_out_flag, zero
    logic enable_reg; // software run enable
    logic squash_reg; // next valid instruction is to be dropped
    logic skipNext_reg; // pulse telling the sequencer a skip was taken
    core_exec_pkg::file_wr_type fileWr_reg; // registered write-back
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // decode and datapath
    logic exec; // instruction really executes this cycle
    logic isFileSrc; // operand comes from the file register
    logic [7:0] operand;
    logic [8:0] sum9; // full sum, bit 8 is carry out of bit 7
    logic [4:0] nib5; // low nibble sum, bit 4 is carry out of bit 3
    logic [7:0] bitMask;
    logic [7:0] result;
    logic toAcc; // result lands in the accumulator
    logic toFile; // result written back to the file register
    logic arith; // carry flags follow
    logic logical; // zero flag follows
    logic skipTaken;
    logic apbAccess;
    logic apbWrite;
    logic addrHit;

    // a dropped slot still takes one cycle, which is how the skip costs two
    assign exec = instrValid && enable_reg && !squash_reg;
    assign isFileSrc = instr.op == core_exec_pkg::ADD_ACC_AND_FILE
        || instr.op == core_exec_pkg::MASK_ACC_WITH_FILE;
    assign operand = isFileSrc ? fileRdData : instr.literal;
    assign sum9 = {1'b0, acc_reg} + {1'b0, operand};
    assign nib5 = {1'b0, acc_reg[3:0]} + {1'b0, operand[3:0]};
    assign bitMask = 8'h01 << instr.bitSel;
    assign skipTaken = exec && instr.op == core_exec_pkg::TEST_BIT_SKIP_ON_ZERO
        && !fileRdData[instr.bitSel];

    // result and routing per instruction
    always_comb begin
        result = acc_reg;
        toAcc = 1'b0;
        toFile = 1'b0;
        arith = 1'b0;
        logical = 1'b0;
        unique case (instr.op)
            core_exec_pkg::ADD_IMMEDIATE_TO_ACC: begin
                result = sum9[7:0];
                toAcc = 1'b1;
                arith = 1'b1;
            end
            core_exec_pkg::ADD_ACC_AND_FILE: begin
                result = sum9[7:0];
                toAcc = instr.dest == core_exec_pkg::DEST_ACC;
                toFile = instr.dest != core_exec_pkg::DEST_ACC;
                arith = 1'b1;
            end
            core_exec_pkg::MASK_IMMEDIATE_WITH_ACC: begin
                result = acc_reg & operand;
                toAcc = 1'b1;
                logical = 1'b1;
            end
            core_exec_pkg::MASK_ACC_WITH_FILE: begin
                result = acc_reg & operand;
                toAcc = instr.dest == core_exec_pkg::DEST_ACC;
                toFile = instr.dest != core_exec_pkg::DEST_ACC;
                logical = 1'b1;
            end
            core_exec_pkg::FILE_BIT_CLEAR_OP: begin
                result = fileRdData & ~bitMask;
                toFile = 1'b1;
            end
            core_exec_pkg::FILE_BIT_SET_OP: begin
                result = fileRdData | bitMask;
                toFile = 1'b1;
            end
            // test and no-op touch neither the accumulator nor any flag
            core_exec_pkg::TEST_BIT_SKIP_ON_ZERO: begin
            end
            core_exec_pkg::NO_OPERATION: begin
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulator: execution wins over a same-cycle software write
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_reg <= core_exec_pkg::ACC_RESET;
        end else if (exec && toAcc) begin
            acc_reg <= result;
        end else if (apbWrite && paddr == core_exec_pkg::ADDR_ACC) begin
            acc_reg <= pwdata[7:0];
        end
    end

    // status flags: carries on adds only, zero on adds and masks
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_reg <= core_exec_pkg::FLAGS_RESET;
        end else if (exec && (arith || logical)) begin
            flags_reg[core_exec_pkg::FLAG_Z] <= result == 8'h00;
            if (arith) begin
                flags_reg[core_exec_pkg::FLAG_C] <= sum9[core_exec_pkg::CARRY_BIT];
                flags_reg[core_exec_pkg::FLAG_NIB] <= nib5[core_exec_pkg::NIBBLE_CARRY_BIT];
            end
        end else if (apbWrite && paddr == core_exec_pkg::ADDR_FLAGS) begin
            flags_reg <= pwdata[core_exec_pkg::FLAG_W-1:0];
        end
    end

    // file write-back, presented one cycle after execution
    always_ff @(posedge clk) begin
        if (rst) begin
            fileWr_reg <= '0;
        end else begin
            fileWr_reg.en <= exec && toFile;
            fileWr_reg.addr <= instr.fileAddr;
            fileWr_reg.data <= result;
        end
    end

    // skip: flag the sequencer and drop the next valid instruction
    always_ff @(posedge clk) begin
        if (rst) begin
            squash_reg <= 1'b0;
            skipNext_reg <= 1'b0;
        end else begin
            skipNext_reg <= skipTaken;
            if (skipTaken) begin
                squash_reg <= 1'b1;
            end else if (instrValid && squash_reg) begin
                squash_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: answers in the first access cycle, no wait states
    assign apbAccess = psel && penable && pready_reg;
    assign apbWrite = apbAccess && pwrite && addrHit;
    assign addrHit = paddr == core_exec_pkg::ADDR_CTRL || paddr == core_exec_pkg::ADDR_ACC
        || paddr == core_exec_pkg::ADDR_FLAGS;

    // control register: bit 0 lets instructions execute
    always_ff @(posedge clk) begin
        if (rst) begin
            enable_reg <= core_exec_pkg::CTRL_ENABLE_RESET;
        end else if (apbWrite && paddr == core_exec_pkg::ADDR_CTRL) begin
            enable_reg <= pwdata[0];
        end
    end

    // read data and response prepared in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= core_exec_pkg::RDATA_ZERO;
        end else begin
            pready_reg <= psel && !penable;
            pslverr_reg <= psel && !penable && !addrHit; // unmapped address
            prdata_reg <= core_exec_pkg::RDATA_ZERO;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    core_exec_pkg::ADDR_CTRL: prdata_reg[0] <= enable_reg;
                    core_exec_pkg::ADDR_ACC: prdata_reg[7:0] <= acc_reg;
                    core_exec_pkg::ADDR_FLAGS: prdata_reg[core_exec_pkg::FLAG_W-1:0] <= flags_reg;
                    default: prdata_reg <= core_exec_pkg::RDATA_ZERO;
                endcase
            end
        end
    end

    assign acc = acc_reg;
    assign flags = flags_reg;
    assign fileWr = fileWr_reg;
    assign skipNext = skipNext_reg;
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    add_imm_acc_a: assert property (@(posedge clk) disable iff (rst)
        exec && instr.op == core_exec_pkg::ADD_IMMEDIATE_TO_ACC
        |=> acc_reg == 8'($past(acc_reg) + $past(instr.literal)))
        else $error("immediate add result wrong");

    add_file_carry_a: assert property (@(posedge clk) disable iff (rst)
        exec && instr.op == core_exec_pkg::ADD_ACC_AND_FILE
        |=> flags_reg[core_exec_pkg::FLAG_C]
            == (9'($past(acc_reg)) + 9'($past(fileRdData)) > 9'h0FF))
        else $error("file add carry wrong");

    dest_file_route_a: assert property (@(posedge clk) disable iff (rst)
        exec && isFileSrc && instr.dest != core_exec_pkg::DEST_ACC
            && !(apbWrite && paddr == core_exec_pkg::ADDR_ACC)
        |=> fileWr_reg.en && fileWr_reg.addr == $past(instr.fileAddr) && $stable(acc_reg))
        else $error("destination routing wrong");

    bit_clear_a: assert property (@(posedge clk) disable iff (rst)
        exec && instr.op == core_exec_pkg::FILE_BIT_CLEAR_OP
            && !(apbWrite && paddr == core_exec_pkg::ADDR_FLAGS)
        |=> fileWr_reg.en && !fileWr_reg.data[$past(instr.bitSel)] && $stable(flags_reg))
        else $error("bit clear wrong");

    bit_set_a: assert property (@(posedge clk) disable iff (rst)
        exec && instr.op == core_exec_pkg::FILE_BIT_SET_OP
        |=> fileWr_reg.data == ($past(fileRdData) | (8'h01 << $past(instr.bitSel))))
        else $error("bit set wrong");

    mask_carry_keep_a: assert property (@(posedge clk) disable iff (rst)
        exec && logical
        |=> $stable(flags_reg[core_exec_pkg::FLAG_C]) && $stable(flags_reg[core_exec_pkg::FLAG_NIB]))
        else $error("mask changed carry flags");

    test_set_runs_a: assert property (@(posedge clk) disable iff (rst)
        exec && instr.op == core_exec_pkg::TEST_BIT_SKIP_ON_ZERO && fileRdData[instr.bitSel]
            && !(apbWrite && paddr == core_exec_pkg::ADDR_FLAGS)
        |=> !skipNext_reg && !squash_reg && $stable(flags_reg))
        else $error("set bit caused a skip");

    test_clr_skips_a: assert property (@(posedge clk) disable iff (rst)
        skipTaken |=> skipNext_reg && !exec ##1 !skipNext_reg)
        else $error("clear bit did not skip");

    zero_flag_a: assert property (@(posedge clk) disable iff (rst)
        exec && toAcc && (arith || logical)
        |=> flags_reg[core_exec_pkg::FLAG_Z] == (acc_reg == 8'h00))
        else $error("zero flag wrong");

endmodule : core_add_and_bit_exec_unit

/* testbench/file_reg_model.sv */
// partner model: data register file seen from the execution unit
`timescale 1ns/100ps

module file_reg_model (
    input wire logic clk,
    input wire logic instrValid,
    input wire logic [6:0] rdAddr,
    input wire core_exec_pkg::file_wr_type fileWr,
    input wire logic preEn,
    input wire logic [6:0] preAddr,
    input wire logic [7:0] preData,
    output logic [7:0] rdData
);
    logic [7:0] mem [128]; // register array

    // read is combinational; outside a valid cycle the operand is not trusted,
    // so the inverse is shown to catch a unit that samples it late
    assign rdData = instrValid ? mem[rdAddr] : ~mem[rdAddr];

    // write-back lands on the edge that samples the one-cycle enable
    always_ff @(posedge clk) begin
        if (fileWr.en) begin
            mem[fileWr.addr] <= fileWr.data;
        end else if (preEn) begin // bench preload
            mem[preAddr] <= preData;
        end
    end
endmodule : file_reg_model

/* testbench/core_add_and_bit_exec_unit_bench.sv */
// bench: instruction and apb stimulus with self-checking results
`timescale 1ns/100ps

module core_add_and_bit_exec_unit_bench;
    logic clk = 1'b0, rst, instrValid, psel, penable, pwrite, preEn, errv;
    logic skipNext, pready, pslverr;
    core_exec_pkg::instr_type instr;
    core_exec_pkg::file_wr_type fileWr;
    logic [7:0] fileRdData, acc, paddr, preData;
    logic [6:0] preAddr;
    logic [core_exec_pkg::FLAG_W-1:0] flags;
    logic [31:0] pwdata, prdata, rdv;
    int nMismatch = 0, numChecks = 0, cycles = 0, skipCount = 0;

    always #5 clk = ~clk; // 100 MHz

    core_add_and_bit_exec_unit u_core_add_and_bit_exec_unit (.clk, .rst, .instrValid,
        .instr, .fileRdData, .fileWr, .skipNext, .acc, .flags, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    file_reg_model u_file_reg_model (.clk, .instrValid, .rdAddr(instr.fileAddr),
        .fileWr, .preEn, .preAddr, .preData, .rdData(fileRdData));

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; waits for pready, no fixed latency assumed; the hang guard ends a stuck wait
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // instruction issue holds valid up so back-to-back issue never toggles it
    task automatic put(input core_exec_pkg::op_type op, input logic [6:0] fa,
        input logic [2:0] b, input logic d, input logic [7:0] k);
        instrValid <= 1'b1;
        instr <= '{op, fa, b, d, k};
        @(posedge clk);
    endtask : put

    task automatic idle(input int n);
        instrValid <= 1'b0;
        // ends on an edge so the next drive is aligned; values read here settled earlier
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic preset(input logic [6:0] a, input logic [7:0] d);
        preEn <= 1'b1;
        preAddr <= a;
        preData <= d;
        @(posedge clk);
        preEn <= 1'b0;
        @(posedge clk);
    endtask : preset

    ////////////////////////////////////////////////////////////////////////
    // control register reset value and an unmapped address
    task automatic t_regs;
        apb(1'b0, core_exec_pkg::ADDR_CTRL, 32'h0000_0000);
        chk(rdv[7:0], 8'h01);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk({7'h00, errv}, 8'h01);
        chk(rdv[7:0], 8'h00);
        $display("test regs done");
    endtask : t_regs

    // adds with carries, both destinations
    task automatic t_add;
        apb(1'b1, core_exec_pkg::ADDR_ACC, 32'h0000_008F);
        put(core_exec_pkg::ADD_IMMEDIATE_TO_ACC, 7'h00, 3'h0, 1'b0, 8'h71);
        idle(1);
        chk(acc, 8'h00);
        chk(8'(flags), 8'h07);
        preset(7'h7F, 8'h0A);
        apb(1'b1, core_exec_pkg::ADDR_ACC, 32'h0000_0005);
        put(core_exec_pkg::ADD_ACC_AND_FILE, 7'h7F, 3'h0, 1'b1, 8'h00);
        idle(2);
        chk(u_file_reg_model.mem[127], 8'h0F);
        chk(acc, 8'h05);
        chk(8'(flags), 8'h00);
        put(core_exec_pkg::ADD_ACC_AND_FILE, 7'h7F, 3'h0, 1'b0, 8'h00);
        idle(1);
        chk(acc, 8'h14);
        chk(8'(flags), 8'h02);
        $display("test add done");
    endtask : t_add

    // masks touch only the zero flag
    task automatic t_mask;
        apb(1'b1, core_exec_pkg::ADDR_FLAGS, 32'h0000_0003);
        put(core_exec_pkg::MASK_IMMEDIATE_WITH_ACC, 7'h00, 3'h0, 1'b0, 8'hEB);
        idle(1);
        chk(acc, 8'h00);
        chk(8'(flags), 8'h07);
        apb(1'b1, core_exec_pkg::ADDR_ACC, 32'h0000_00F0);
        preset(7'h33, 8'h3C);
        put(core_exec_pkg::MASK_ACC_WITH_FILE, 7'h33, 3'h0, 1'b1, 8'h00);
        idle(2);
        chk(u_file_reg_model.mem[51], 8'h30);
        chk(acc, 8'hF0);
        chk(8'(flags), 8'h03);
        $display("test mask done");
    endtask : t_mask

    // back-to-back bit clear and set at the bit-number extremes
    task automatic t_bits;
        preset(7'h03, 8'hFF);
        preset(7'h04, 8'h00);
        put(core_exec_pkg::FILE_BIT_CLEAR_OP, 7'h03, 3'h7, 1'b0, 8'h00);
        put(core_exec_pkg::FILE_BIT_SET_OP, 7'h04, 3'h0, 1'b0, 8'h00);
        idle(2);
        chk(u_file_reg_model.mem[3], 8'h7F);
        chk(u_file_reg_model.mem[4], 8'h01);
        chk(8'(flags), 8'h03);
        $display("test bits done");
    endtask : t_bits

    // taken and untaken skip, then a refused instruction while disabled
    task automatic t_skip;
        preset(7'h05, 8'hFB);
        put(core_exec_pkg::TEST_BIT_SKIP_ON_ZERO, 7'h05, 3'h2, 1'b0, 8'h00);
        put(core_exec_pkg::ADD_IMMEDIATE_TO_ACC, 7'h00, 3'h0, 1'b0, 8'h01);
        idle(1);
        chk(8'(skipCount), 8'h01);
        chk(acc, 8'hF0);
        chk(8'(flags), 8'h03);
        put(core_exec_pkg::TEST_BIT_SKIP_ON_ZERO, 7'h05, 3'h3, 1'b0, 8'h00);
        put(core_exec_pkg::ADD_IMMEDIATE_TO_ACC, 7'h00, 3'h0, 1'b0, 8'h01);
        idle(1);
        chk(8'(skipCount), 8'h01);
        chk(acc, 8'hF1);
        chk(8'(flags), 8'h00);
        apb(1'b1, core_exec_pkg::ADDR_CTRL, 32'h0000_0000);
        put(core_exec_pkg::ADD_IMMEDIATE_TO_ACC, 7'h00, 3'h0, 1'b0, 8'h01);
        idle(1);
        chk(acc, 8'hF1);
        apb(1'b1, core_exec_pkg::ADDR_CTRL, 32'h0000_0001);
        $display("test skip done");
    endtask : t_skip

    ////////////////////////////////////////////////////////////////////////
    // skip pulses counted at the falling edge, where the registered pulse has settled
    always @(negedge clk) begin
        if (skipNext === 1'b1) skipCount++;
    end

    // hang guard: the tests need well under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            nMismatch++;
            end_sim();
        end
    end

    // main sequence
    initial begin
        rst = 1'b1;
        instrValid = 1'b0;
        instr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        preEn = 1'b0;
        preAddr = 7'h00;
        preData = 8'h00;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_add();
        t_mask();
        t_bits();
        t_skip();
        end_sim();
    end
endmodule : core_add_and_bit_exec_unit_bench
